// >>> verilog/ptp_time_defines.svh
`ifndef PTP_TIME_DEFINES_SVH
`define PTP_TIME_DEFINES_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define PTP_SEC_W 32
`define PTP_SUB_W 32
`define PTP_ACC_W 32
`define PTP_INC_W 8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PTP_SUB_MSB 30
`define PTP_SIGN_BIT 31

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PTP_SEC_RST 32'h0000_0000
`define PTP_SUB_RST 32'h0000_0000
`define PTP_ACC_RST 32'h0000_0000
`define PTP_ADDEND_RST 32'h0000_0000

`endif

// >>> verilog/ptp_time_pkg.sv
`default_nettype none
package ptp_time_pkg;

  // ----------------------------------------------------------------
  // system time carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] seconds;
    logic [31:0] subseconds;
  } sys_time_t;

  // ----------------------------------------------------------------
  // state of the time unit, apart from the reset release registers
  // ----------------------------------------------------------------
  typedef struct packed {
    sys_time_t now;
    logic [31:0] acc;
    logic [31:0] addend;
    logic init_pend;
    logic upd_pend;
    logic add_pend;
    logic running;
    logic reached;
    logic flag;
    sys_time_t stamp;
    logic stamp_valid;
  } time_state_t;

endpackage

`default_nettype wire

// >>> verilog/ptp_system_time_unit.sv
`timescale 1ns/1ns
`default_nettype none
`include "ptp_time_defines.svh"

module ptp_system_time_unit
  import ptp_time_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // control bits
  input wire logic timestamp_enable_in,
  input wire logic fine_correction_sel_in,
  input wire logic trigger_enable_in,
  input wire logic trigger_irq_mask_in,
  // command set strobes
  input wire logic time_init_cmd_in,
  input wire logic time_update_cmd_in,
  input wire logic addend_update_req_in,
  // command bits as read back
  output logic time_init_cmd_out,
  output logic time_update_cmd_out,
  output logic addend_update_req_out,
  // update, addend, increment and target values
  input wire logic [31:0] update_seconds_in,
  input wire logic [31:0] update_subseconds_in,
  input wire logic [31:0] addend_in,
  input wire logic [7:0] subsecond_increment_in,
  input wire logic [31:0] target_seconds_in,
  input wire logic [31:0] target_subseconds_in,
  // flag register read strobe
  input wire logic flag_read_in,
  // frame start of frame delimiter strobe
  input wire logic frame_sfd_in,
  // time and stamp outputs
  output sys_time_t system_time_out,
  output sys_time_t stamp_out,
  output logic stamp_valid_out,
  // trigger outputs
  output logic trigger_out,
  output logic trigger_flag_out,
  output logic trigger_irq_out
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge ref_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // time arithmetic
  // ----------------------------------------------------------------
  function automatic sys_time_t add_time(input sys_time_t t,
                                         input logic [31:0] ds,
                                         input logic [30:0] dsub);
    logic [31:0] sum;
    sys_time_t r;
    sum = {1'b0, t.subseconds[`PTP_SUB_MSB:0]} + {1'b0, dsub};
    r.seconds = t.seconds + ds;
    if (sum[`PTP_SIGN_BIT])
      r.seconds = r.seconds + 32'h0000_0001;
    r.subseconds = {1'b0, sum[`PTP_SUB_MSB:0]};
    return r;
  endfunction

  function automatic sys_time_t sub_time(input sys_time_t t,
                                         input logic [31:0] ds,
                                         input logic [30:0] dsub);
    logic [31:0] dif;
    sys_time_t r;
    dif = {1'b0, t.subseconds[`PTP_SUB_MSB:0]} - {1'b0, dsub};
    r.seconds = t.seconds - ds;
    if (dif[`PTP_SIGN_BIT])
      r.seconds = r.seconds - 32'h0000_0001;
    r.subseconds = {1'b0, dif[`PTP_SUB_MSB:0]};
    return r;
  endfunction

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  time_state_t st_reg;
  time_state_t st_next;
  logic [32:0] acc_sum;
  logic tick;
  logic at_target;
  sys_time_t target;
  sys_time_t upd_val;

  assign target = {target_seconds_in, target_subseconds_in};
  assign upd_val = {update_seconds_in, update_subseconds_in};
  assign acc_sum = {1'b0, st_reg.acc} + {1'b0, st_reg.addend};
  assign tick = fine_correction_sel_in ? acc_sum[32] : 1'b1;
  assign at_target = st_reg.now >= target;

  always_comb
  begin
    st_next = st_reg;
    st_next.stamp_valid = 1'b0;
    // advance while running
    st_next.running = st_reg.running & timestamp_enable_in;
    if (st_reg.running)
    begin
      if (fine_correction_sel_in)
        st_next.acc = acc_sum[31:0];
      if (tick)
        st_next.now = add_time(st_reg.now, 32'h0000_0000,
          {23'h0, subsecond_increment_in});
    end
    // coarse commands take the place of the step
    if (st_reg.init_pend)
    begin
      st_next.now.seconds = update_seconds_in;
      st_next.now.subseconds = {1'b0,
        update_subseconds_in[`PTP_SUB_MSB:0]};
      st_next.acc = `PTP_ACC_RST;
      st_next.running = timestamp_enable_in;
    end
    else if (st_reg.upd_pend)
    begin
      if (update_subseconds_in[`PTP_SIGN_BIT])
        st_next.now = sub_time(st_reg.now, upd_val.seconds,
          upd_val.subseconds[`PTP_SUB_MSB:0]);
      else
        st_next.now = add_time(st_reg.now, upd_val.seconds,
          upd_val.subseconds[`PTP_SUB_MSB:0]);
    end
    if (st_reg.add_pend)
      st_next.addend = addend_in;
    // command bits: set wins over the device clear
    st_next.init_pend = time_init_cmd_in;
    st_next.upd_pend = time_update_cmd_in |
      (st_reg.upd_pend & st_reg.init_pend);
    st_next.add_pend = addend_update_req_in;
    // frame stamp
    if (frame_sfd_in && timestamp_enable_in)
    begin
      st_next.stamp = st_reg.now;
      st_next.stamp_valid = 1'b1;
    end
    // trigger
    st_next.reached = trigger_enable_in & st_reg.running & at_target;
    st_next.flag = (st_reg.flag & ~flag_read_in) |
      (st_next.reached & ~st_reg.reached);
  end

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg.now <= {`PTP_SEC_RST, `PTP_SUB_RST};
      st_reg.acc <= `PTP_ACC_RST;
      st_reg.addend <= `PTP_ADDEND_RST;
      st_reg.init_pend <= 1'b0;
      st_reg.upd_pend <= 1'b0;
      st_reg.add_pend <= 1'b0;
      st_reg.running <= 1'b0;
      st_reg.reached <= 1'b0;
      st_reg.flag <= 1'b0;
      st_reg.stamp <= {`PTP_SEC_RST, `PTP_SUB_RST};
      st_reg.stamp_valid <= 1'b0;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign time_init_cmd_out = st_reg.init_pend;
  assign time_update_cmd_out = st_reg.upd_pend;
  assign addend_update_req_out = st_reg.add_pend;
  assign system_time_out = st_reg.now;
  assign stamp_out = st_reg.stamp;
  assign stamp_valid_out = st_reg.stamp_valid;
  assign trigger_out = st_reg.reached;
  assign trigger_flag_out = st_reg.flag;
  assign trigger_irq_out = st_reg.flag & ~trigger_irq_mask_in;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n);

  init_load_a: assert property (
    st_reg.init_pend |=> st_reg.now ==
      {$past(update_seconds_in), 1'b0,
       $past(update_subseconds_in[`PTP_SUB_MSB:0])})
    else $error("init did not load update value");

  init_start_a: assert property (
    st_reg.init_pend && timestamp_enable_in |=> st_reg.running)
    else $error("counter not running after init");

  upd_clear_a: assert property (
    st_reg.upd_pend && !st_reg.init_pend && !time_update_cmd_in
      |=> !st_reg.upd_pend)
    else $error("update bit not cleared");

  upd_add_a: assert property (
    st_reg.upd_pend && !st_reg.init_pend &&
      !update_subseconds_in[`PTP_SIGN_BIT] &&
      ({1'b0, st_reg.now.subseconds[`PTP_SUB_MSB:0]} +
       {1'b0, update_subseconds_in[`PTP_SUB_MSB:0]}) < 32'h8000_0000
      |=> st_reg.now.seconds ==
        $past(st_reg.now.seconds) + $past(update_seconds_in))
    else $error("coarse add wrong");

  addend_load_a: assert property (
    st_reg.add_pend && !addend_update_req_in
      |=> st_reg.addend == $past(addend_in) && !st_reg.add_pend)
    else $error("addend not applied");

  fine_hold_a: assert property (
    st_reg.running && fine_correction_sel_in && !acc_sum[32] &&
      !st_reg.init_pend && !st_reg.upd_pend
      |=> $stable(st_reg.now))
    else $error("time moved without overflow");

  fine_acc_a: assert property (
    st_reg.running && fine_correction_sel_in && !st_reg.init_pend
      |=> st_reg.acc == $past(acc_sum[31:0]))
    else $error("accumulator did not add addend");

  sec_wrap_a: assert property (
    st_reg.running && !fine_correction_sel_in &&
      !st_reg.init_pend && !st_reg.upd_pend &&
      ({1'b0, st_reg.now.subseconds[`PTP_SUB_MSB:0]} +
       {24'h000000, subsecond_increment_in}) >= 32'h8000_0000
      |=> st_reg.now.seconds == $past(st_reg.now.seconds) + 32'h1)
    else $error("seconds not carried");

  trig_level_a: assert property (
    trigger_enable_in && st_reg.running && at_target |=> trigger_out)
    else $error("trigger missed");

  irq_mask_a: assert property (
    trigger_irq_mask_in |-> !trigger_irq_out)
    else $error("masked trigger raised irq");

  flag_read_a: assert property (
    flag_read_in && !(st_next.reached && !st_reg.reached)
      |=> !trigger_flag_out)
    else $error("flag not cleared by read");

  stamp_copy_a: assert property (
    frame_sfd_in && timestamp_enable_in
      |=> stamp_valid_out && stamp_out == $past(st_reg.now))
    else $error("stamp not current time");

  upd_sub_a: assert property (
    st_reg.upd_pend && !st_reg.init_pend &&
      update_subseconds_in[`PTP_SIGN_BIT] &&
      st_reg.now.subseconds[`PTP_SUB_MSB:0] >=
        update_subseconds_in[`PTP_SUB_MSB:0]
      |=> st_reg.now.seconds ==
        $past(st_reg.now.seconds) - $past(update_seconds_in))
    else $error("coarse subtract wrong");

  coarse_step_a: assert property (
    st_reg.running && !fine_correction_sel_in &&
      !st_reg.init_pend && !st_reg.upd_pend &&
      ({1'b0, st_reg.now.subseconds[`PTP_SUB_MSB:0]} +
       {24'h000000, subsecond_increment_in}) < 32'h8000_0000
      |=> st_reg.now.subseconds ==
        $past(st_reg.now.subseconds) +
        $past({24'h000000, subsecond_increment_in}))
    else $error("coarse step wrong");

  idle_hold_a: assert property (
    !st_reg.running && !st_reg.init_pend && !st_reg.upd_pend
      |=> $stable(st_reg.now))
    else $error("time moved while stopped");

  irq_open_a: assert property (
    !trigger_irq_mask_in && trigger_flag_out |-> trigger_irq_out)
    else $error("unmasked flag gave no irq");

endmodule

`default_nettype wire

// >>> dv/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import ptp_time_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ts_en, fine_sel, trig_en, trig_mask, init_c, upd_c, add_c, fread, sfd;
  logic [31:0] u_sec, u_sub, addend, t_sec, t_sub;
  logic [7:0] inc;
  logic init_o, upd_o, add_o, stamp_v, trig_o, flag_o, irq_o;
  sys_time_t now, stamp, t0, t1;
  sys_time_t exp_q[$];
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #50 clk = ~clk;

  ptp_system_time_unit u_ptp_system_time_unit (
    .ref_clk_in(clk), .nrst_in(nrst),
    .timestamp_enable_in(ts_en), .fine_correction_sel_in(fine_sel),
    .trigger_enable_in(trig_en), .trigger_irq_mask_in(trig_mask),
    .time_init_cmd_in(init_c), .time_update_cmd_in(upd_c),
    .addend_update_req_in(add_c), .time_init_cmd_out(init_o),
    .time_update_cmd_out(upd_o), .addend_update_req_out(add_o),
    .update_seconds_in(u_sec), .update_subseconds_in(u_sub),
    .addend_in(addend), .subsecond_increment_in(inc),
    .target_seconds_in(t_sec), .target_subseconds_in(t_sub),
    .flag_read_in(fread), .frame_sfd_in(sfd),
    .system_time_out(now), .stamp_out(stamp), .stamp_valid_out(stamp_v),
    .trigger_out(trig_o), .trigger_flag_out(flag_o), .trigger_irq_out(irq_o)
  );

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      close_out();
    end
  end

  always @(negedge clk)
    if (stamp_v === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("stamp_extra", 1'b1, 1'b0);
      else
        check("stamp", stamp, exp_q.pop_front());
    end

  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic pulse_cmd(input int k);
    @(negedge clk);
    case (k)
      0: init_c = 1'b1;
      1: upd_c = 1'b1;
      2: add_c = 1'b1;
      3:
      begin
        sfd = 1'b1;
        if (ts_en)
          exp_q.push_back(now);
      end
      default: fread = 1'b1;
    endcase
    @(negedge clk);
    {init_c, upd_c, add_c, sfd, fread} = '0;
  endtask

  function automatic logic pend(input int k);
    return k == 0 ? init_o : (k == 1 ? upd_o : add_o);
  endfunction

  task automatic run_cmd(input int k);
    int n;
    pulse_cmd(k);
    check("cmd_pending", pend(k), 1'b1);
    n = 0;
    while (pend(k) !== 1'b0 && n < 6)
    begin
      @(negedge clk);
      n++;
    end
    check("cmd_cleared", pend(k), 1'b0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {ts_en, fine_sel, trig_en, trig_mask} = '0;
    {init_c, upd_c, add_c, sfd, fread} = '0;
    {u_sec, u_sub, addend, t_sec, t_sub} = '0;
    inc = 8'h10;
    void'($urandom(35));
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    check("reset_time", now, 64'h0);
    trig_mask = 1'b1;
    ts_en = 1'b1;
    fine_sel = 1'b1;
    u_sec = $urandom;
    u_sub = ($urandom & 32'h2fff_ffff) | 32'h1000_0000;
    run_cmd(0);
    check("init_load", now, {u_sec, u_sub});
    $display("test init done");
    for (int i = 0; i < 2; i++)
    begin
      t0 = now;
      u_sec = $urandom;
      u_sub = $urandom & 32'h0fff_ffff;
      t1.seconds = i ? t0.seconds - u_sec : t0.seconds + u_sec;
      t1.subseconds = i ? t0.subseconds - u_sub : t0.subseconds + u_sub;
      u_sub[31] = i[0];
      run_cmd(1);
      check("update_value", now, t1);
    end
    $display("test update done");
    pulse_cmd(3);
    repeat (2) @(negedge clk);
    $display("test stamp done");
    fine_sel = 1'b0;
    inc = 8'h20;
    u_sec = 32'h0000_0005;
    u_sub = 32'h7fff_ff00;
    run_cmd(0);
    @(negedge clk);
    repeat (12)
    begin
      t0 = now;
      @(negedge clk);
      t1 = t0;
      t1.subseconds = t0.subseconds + {24'h0, inc};
      if (t1.subseconds[31])
      begin
        t1.subseconds[31] = 1'b0;
        t1.seconds = t0.seconds + 32'h1;
      end
      check("coarse_step", now, t1);
    end
    $display("test coarse done");
    t_sec = now.seconds;
    t_sub = now.subseconds + 32'h200;
    trig_mask = 1'b1;
    trig_en = 1'b1;
    t0 = now;
    repeat (24)
    begin
      @(negedge clk);
      check("trigger", trig_o, t0 >= {t_sec, t_sub});
      t0 = now;
    end
    check("flag_set", flag_o, 1'b1);
    check("irq_masked", irq_o, 1'b0);
    trig_mask = 1'b0;
    #1;
    check("irq_open", irq_o, 1'b1);
    pulse_cmd(4);
    @(negedge clk);
    check("flag_cleared", flag_o, 1'b0);
    check("irq_cleared", irq_o, 1'b0);
    trig_en = 1'b0;
    $display("test trigger done");
    fine_sel = 1'b1;
    addend = 32'h8000_0000;
    run_cmd(2);
    t0 = now;
    repeat (8) @(negedge clk);
    check("fine_rate", now.subseconds - t0.subseconds,
          {inc, 2'b00});
    pulse_cmd(3);
    @(negedge clk);
    $display("test fine done");
    ts_en = 1'b0;
    @(negedge clk);
    t0 = now;
    pulse_cmd(3);
    ts_en = 1'b1;
    repeat (2) @(negedge clk);
    check("enable_hold", now, t0);
    u_sec = $urandom;
    u_sub = $urandom & 32'h7fff_ffff;
    run_cmd(0);
    check("reinit_load", now, {u_sec, u_sub});
    $display("test enable done");
    check("stamp_queue", exp_q.size(), 0);
    close_out();
  end
endmodule
`default_nettype wire
